// ### pkg/cir_pkg.sv
package cir_pkg;

    // ==========================================================
    // Entry points and vector composition
    localparam logic [15:0] NMI_ENTRY = 16'h0066;
    localparam logic [15:0] MODE1_ENTRY = 16'h0038;
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_RESET = MODE_0;

    // ==========================================================
    // T-state indices (zero based) per machine cycle
    localparam logic [2:0] T_NOP_LAST = 3'h3;
    localparam logic [2:0] T_FETCH_LAST = 3'h3;
    localparam logic [2:0] T_ACK_WAITS = 3'h2;
    localparam logic [2:0] T_ACK_CAP = 3'h4;
    localparam logic [2:0] T_ACK_LAST = 3'h5;
    localparam logic [2:0] T_RD_CAP = 3'h2;
    localparam logic [2:0] T_RD_LAST = 3'h2;
    localparam logic [2:0] T_STROBE_LAST = 3'h1;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_COUNT = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam int CTRL_CLR_BIT = 0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ==========================================================
    // Sequencer states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_HALT = 7'h02,
        S_NMI_FETCH = 7'h04,
        S_ACK = 7'h08,
        S_TBL_LO = 7'h10,
        S_TBL_HI = 7'h20,
        S_DONE = 7'h40
    } cir_state_t;

    typedef enum logic [1:0] {
        K_NMI = 2'h0,
        K_MODE0 = 2'h1,
        K_MODE1 = 2'h2,
        K_MODE2 = 2'h3
    } cir_kind_t;

    // Bus strobes, all active low
    typedef struct packed {
        logic opcode_fetch_cycle_n;
        logic mem_request_n;
        logic read_n;
        logic io_request_strobe_n;
    } cir_bus_t;

    localparam cir_bus_t BUS_IDLE = 4'hF;

    // Service order handed to the core
    typedef struct packed {
        logic valid;
        cir_kind_t kind;
        logic push_pc;
        logic [15:0] target;
        logic [7:0] opcode;
    } cir_svc_t;

endpackage : cir_pkg

// ### rtl/cir_unit.sv
`timescale 1ns/1ps
`default_nettype none

module cir_unit
    import cir_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Pins from outside
    input wire logic nmi_req_n_i,
    input wire logic int_req_n_i,
    input wire logic bus_takeover_request_n_i,
    // Core instruction decode
    input wire logic instr_end_i,
    input wire logic halt_i,
    input wire logic unmask_op_i,
    input wire logic mask_off_op_i,
    input wire logic response_kind_select_op_i,
    input wire logic [1:0] response_kind_i,
    input wire logic load_page_op_i,
    input wire logic [7:0] accumulator_i,
    input wire logic nonmaskable_exit_op_i,
    input wire logic vectored_exit_op_i,
    input wire logic [15:0] pc_i,
    // External bus
    input wire logic [7:0] data_i,
    output cir_bus_t bus_o,
    output logic [15:0] addr_o,
    // Service order and state to core
    output cir_svc_t svc_o,
    output logic pc_hold_o,
    output logic enable_flop_primary_o,
    output logic enable_flop_shadow_o,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);

    // ==========================================================
    // Pin synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic nmi_prev_q;
    logic nmi_pend_q;
    logic nmi_s;
    logic int_s;
    logic bus_takeover_request_s;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {~bus_takeover_request_n_i, ~int_req_n_i, ~nmi_req_n_i};
            sync2_q <= sync1_q;
        end
    end

    assign nmi_s = sync2_q[0];
    assign int_s = sync2_q[1];
    assign bus_takeover_request_s = sync2_q[2];

    // ==========================================================
    // State and decisions
    cir_state_t state_q;
    logic [2:0] tcnt_q;
    logic [1:0] mode_q;
    logic [7:0] page_q;
    logic [7:0] vec_q;
    logic [7:0] tbl_lo_q;
    logic [7:0] tbl_hi_q;
    logic enable_flop_primary_q;
    logic enable_flop_shadow_q;
    logic sample;
    logic take_nmi;
    logic take_int;
    logic nmi_edge;

    function automatic logic at_t(input logic [2:0] cnt, input logic [2:0] idx);
        at_t = (cnt == idx);
    endfunction : at_t

    assign nmi_edge = nmi_s && !nmi_prev_q;
    assign sample = ((state_q == S_IDLE) && instr_end_i && !halt_i)
                  || ((state_q == S_HALT) && at_t(tcnt_q, T_NOP_LAST));
    assign take_nmi = sample && !bus_takeover_request_s && nmi_pend_q;
    assign take_int = sample && !bus_takeover_request_s && !nmi_pend_q && int_s && enable_flop_primary_q;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_prev_q <= nmi_s;
            if (nmi_edge) begin
                nmi_pend_q <= 1'b1;
            end else if (take_nmi) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Enable flops
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            enable_flop_primary_q <= 1'b0;
            enable_flop_shadow_q <= 1'b0;
        end else if (take_nmi) begin
            enable_flop_shadow_q <= enable_flop_primary_q;
            enable_flop_primary_q <= 1'b0;
        end else if (take_int) begin
            enable_flop_primary_q <= 1'b0;
            enable_flop_shadow_q <= 1'b0;
        end else if (unmask_op_i) begin
            enable_flop_primary_q <= 1'b1;
            enable_flop_shadow_q <= 1'b1;
        end else if (mask_off_op_i) begin
            enable_flop_primary_q <= 1'b0;
            enable_flop_shadow_q <= 1'b0;
        end else if (nonmaskable_exit_op_i) begin
            enable_flop_primary_q <= enable_flop_shadow_q;
        end
    end

    // ==========================================================
    // Mode and page register
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= MODE_RESET;
        end else if (response_kind_select_op_i) begin
            mode_q <= response_kind_i;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            page_q <= 8'h00;
        end else if (load_page_op_i) begin
            page_q <= accumulator_i;
        end
    end

    // ==========================================================
    // Machine cycle sequencer
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= S_IDLE;
            tcnt_q <= 3'h0;
        end else begin
            tcnt_q <= tcnt_q + 3'h1;
            unique case (state_q)
                S_IDLE, S_HALT: begin
                    tcnt_q <= 3'h0;
                    if (take_nmi) begin
                        state_q <= S_NMI_FETCH;
                    end else if (take_int) begin
                        state_q <= S_ACK;
                    end else if (state_q == S_IDLE && halt_i) begin
                        state_q <= S_HALT;
                    end else if (state_q == S_HALT && !at_t(tcnt_q, T_NOP_LAST)) begin
                        tcnt_q <= tcnt_q + 3'h1;
                    end
                end
                S_NMI_FETCH: begin
                    if (at_t(tcnt_q, T_FETCH_LAST)) begin
                        state_q <= S_DONE;
                    end
                end
                S_ACK: begin
                    if (at_t(tcnt_q, T_ACK_LAST)) begin
                        tcnt_q <= 3'h0;
                        state_q <= (mode_q == MODE_2) ? S_TBL_LO : S_DONE;
                    end
                end
                S_TBL_LO: begin
                    if (at_t(tcnt_q, T_RD_LAST)) begin
                        tcnt_q <= 3'h0;
                        state_q <= S_TBL_HI;
                    end
                end
                S_TBL_HI: begin
                    if (at_t(tcnt_q, T_RD_LAST)) begin
                        state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    tcnt_q <= 3'h0;
                    state_q <= S_IDLE;
                end
                default: begin
                    tcnt_q <= 3'h0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Fetched byte in the NMI cycle is never captured
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            vec_q <= 8'h00;
            tbl_lo_q <= 8'h00;
            tbl_hi_q <= 8'h00;
        end else begin
            if (state_q == S_ACK && at_t(tcnt_q, T_ACK_CAP)) begin
                vec_q <= data_i;
            end
            if (state_q == S_TBL_LO && at_t(tcnt_q, T_RD_CAP)) begin
                tbl_lo_q <= data_i;
            end
            if (state_q == S_TBL_HI && at_t(tcnt_q, T_RD_CAP)) begin
                tbl_hi_q <= data_i;
            end
        end
    end

    // ==========================================================
    // Bus strobes and address, registered
    cir_bus_t bus_d;
    logic [15:0] addr_d;

    always_comb begin
        bus_d = BUS_IDLE;
        addr_d = pc_i;
        unique case (state_q)
            S_HALT, S_NMI_FETCH: begin
                if (tcnt_q <= T_STROBE_LAST) begin
                    bus_d.opcode_fetch_cycle_n = 1'b0;
                    bus_d.mem_request_n = 1'b0;
                    bus_d.read_n = 1'b0;
                end
            end
            S_ACK: begin
                if (tcnt_q < T_ACK_LAST) begin
                    bus_d.opcode_fetch_cycle_n = 1'b0;
                end
                if (tcnt_q >= T_ACK_WAITS && tcnt_q < T_ACK_LAST) begin
                    bus_d.io_request_strobe_n = 1'b0;
                end
            end
            S_TBL_LO, S_TBL_HI: begin
                addr_d = {page_q, vec_q} + {15'h0000, state_q == S_TBL_HI};
                if (tcnt_q <= T_STROBE_LAST) begin
                    bus_d.mem_request_n = 1'b0;
                    bus_d.read_n = 1'b0;
                end
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            bus_o <= BUS_IDLE;
            addr_o <= 16'h0000;
        end else begin
            bus_o <= bus_d;
            addr_o <= addr_d;
        end
    end

    // ==========================================================
    // Service order to the core
    logic served_nmi_q;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            served_nmi_q <= 1'b0;
        end else if (take_nmi) begin
            served_nmi_q <= 1'b1;
        end else if (take_int) begin
            served_nmi_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            svc_o <= '0;
        end else begin
            svc_o <= '0;
            if (state_q == S_DONE) begin
                svc_o.valid <= 1'b1;
                svc_o.opcode <= vec_q;
                if (served_nmi_q) begin
                    svc_o.kind <= K_NMI;
                    svc_o.push_pc <= 1'b1;
                    svc_o.target <= NMI_ENTRY;
                end else if (mode_q == MODE_1) begin
                    svc_o.kind <= K_MODE1;
                    svc_o.push_pc <= 1'b1;
                    svc_o.target <= MODE1_ENTRY;
                end else if (mode_q == MODE_2) begin
                    svc_o.kind <= K_MODE2;
                    svc_o.push_pc <= 1'b1;
                    svc_o.target <= {tbl_hi_q, tbl_lo_q};
                end else begin
                    svc_o.kind <= K_MODE0;
                end
            end
        end
    end

    // Program counter frozen until the injected instruction ends
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pc_hold_o <= 1'b0;
        end else if (state_q == S_DONE && !served_nmi_q && mode_q == MODE_0) begin
            pc_hold_o <= 1'b1;
        end else if (instr_end_i) begin
            pc_hold_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            enable_flop_primary_o <= 1'b0;
            enable_flop_shadow_o <= 1'b0;
        end else begin
            enable_flop_primary_o <= enable_flop_primary_q;
            enable_flop_shadow_o <= enable_flop_shadow_q;
        end
    end

    // ==========================================================
    // Event counters and nesting depth
    logic [15:0] nmi_cnt_q;
    logic [15:0] int_cnt_q;
    logic [7:0] depth_q;
    logic ctrl_clr;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            nmi_cnt_q <= 16'h0000;
            int_cnt_q <= 16'h0000;
        end else begin
            if (take_nmi) begin
                nmi_cnt_q <= ctrl_clr ? 16'h0001 : nmi_cnt_q + 16'h0001;
            end else if (ctrl_clr) begin
                nmi_cnt_q <= 16'h0000;
            end
            if (take_int) begin
                int_cnt_q <= ctrl_clr ? 16'h0001 : int_cnt_q + 16'h0001;
            end else if (ctrl_clr) begin
                int_cnt_q <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            depth_q <= 8'h00;
        end else if (take_int && !vectored_exit_op_i) begin
            depth_q <= depth_q + 8'h01;
        end else if (!take_int && vectored_exit_op_i && depth_q != 8'h00) begin
            depth_q <= depth_q - 8'h01;
        end
    end

    // ==========================================================
    // AHB-Lite slave, zero wait, always OKAY
    logic wr_pend_q;
    logic [7:0] wr_addr_q;

    assign ctrl_clr = wr_pend_q && (wr_addr_q == REG_CTRL) && hwdata_i[CTRL_CLR_BIT];

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_o <= RD_ZERO;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend_q <= 1'b0;
            if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
                wr_pend_q <= hwrite_i;
                wr_addr_q <= haddr_i[7:0];
                hrdata_o <= RD_ZERO;
                if (!hwrite_i && haddr_i[31:8] == 24'h000000) begin
                    unique case (haddr_i[7:0])
                        REG_STATUS: hrdata_o <= {depth_q, page_q, 5'h00,
                                                 state_q, mode_q, enable_flop_shadow_q, enable_flop_primary_q};
                        REG_COUNT: hrdata_o <= {int_cnt_q, nmi_cnt_q};
                        default: hrdata_o <= RD_ZERO;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_ack_wait;
        (state_q == S_ACK && tcnt_q == 3'h0) ##2 (state_q == S_ACK);
    endsequence

    property p_nmi_taken;
        @(posedge clock_i) disable iff (reset_i)
        (sample && !bus_takeover_request_s && nmi_pend_q) |=> (state_q == S_NMI_FETCH);
    endproperty
    a_nmi_taken: assert property (p_nmi_taken) else $error("nmi not taken");

    property p_bus_takeover_request_blocks;
        @(posedge clock_i) disable iff (reset_i)
        (sample && bus_takeover_request_s) |=> !(state_q inside {S_NMI_FETCH, S_ACK});
    endproperty
    a_bus_takeover_request_blocks: assert property (p_bus_takeover_request_blocks) else $error("bus request ignored");

    property p_nmi_entry;
        @(posedge clock_i) disable iff (reset_i)
        (state_q == S_NMI_FETCH && tcnt_q == 3'h0) |-> ##5 (svc_o.valid
            && svc_o.target == NMI_ENTRY && svc_o.push_pc);
    endproperty
    a_nmi_entry: assert property (p_nmi_entry) else $error("bad nmi entry");

    property p_nmi_saves;
        @(posedge clock_i) disable iff (reset_i)
        take_nmi |=> (!enable_flop_primary_q && enable_flop_shadow_q == $past(enable_flop_primary_q));
    endproperty
    a_nmi_saves: assert property (p_nmi_saves) else $error("enable not saved");

    property p_int_needs_enable;
        @(posedge clock_i) disable iff (reset_i)
        (state_q != S_ACK) ##1 (state_q == S_ACK) |-> $past(enable_flop_primary_q);
    endproperty
    a_int_needs_enable: assert property (p_int_needs_enable) else $error("masked int taken");

    property p_ack_strobes;
        @(posedge clock_i) disable iff (reset_i)
        s_ack_wait |=> (!bus_o.io_request_strobe_n && bus_o.read_n
            && !bus_o.opcode_fetch_cycle_n) [*3];
    endproperty
    a_ack_strobes: assert property (p_ack_strobes) else $error("ack strobes wrong");

    property p_int_clears;
        @(posedge clock_i) disable iff (reset_i)
        take_int |=> (!enable_flop_primary_q && !enable_flop_shadow_q);
    endproperty
    a_int_clears: assert property (p_int_clears) else $error("enables not cleared");

    property p_mode1_entry;
        @(posedge clock_i) disable iff (reset_i)
        (svc_o.valid && svc_o.kind == K_MODE1) |-> (svc_o.target == MODE1_ENTRY);
    endproperty
    a_mode1_entry: assert property (p_mode1_entry) else $error("bad mode 1 entry");

    property p_mode2_table;
        @(posedge clock_i) disable iff (reset_i)
        (state_q == S_TBL_LO && tcnt_q == 3'h0) |=> (addr_o == {page_q, vec_q});
    endproperty
    a_mode2_table: assert property (p_mode2_table) else $error("bad table address");

    property p_halt_nop;
        @(posedge clock_i) disable iff (reset_i)
        (state_q == S_HALT && tcnt_q == 3'h0) ##1 (state_q == S_HALT)
            |-> (tcnt_q == 3'h1) ##1 (state_q != S_HALT || tcnt_q == 3'h2);
    endproperty
    a_halt_nop: assert property (p_halt_nop) else $error("halt cycle length");

endmodule : cir_unit

`default_nettype wire

// ### sim/cir_periph.sv
`timescale 1ns/1ps
`default_nettype none

module cir_periph
    import cir_pkg::*;
(
    // Bus side
    input wire logic clock_i,
    input wire cir_bus_t bus_i,
    input wire logic [15:0] addr_i,
    // Programmed contents
    input wire logic [7:0] vector_i,
    input wire logic [15:0] table_i,
    input wire logic [15:0] entry_i,
    input wire logic [7:0] code_i,
    output logic [7:0] data_o,
    output logic in_service_o
);
    logic [7:0] data_q = 8'h5A;
    logic ack;
    logic tbl;
    logic fetch;
    logic fetch_q = 1'b0;
    logic ed_seen_q = 1'b0;
    logic in_service_q = 1'b0;

    assign data_o = data_q;
    assign in_service_o = in_service_q;
    assign ack = !bus_i.opcode_fetch_cycle_n && bus_i.read_n && !bus_i.io_request_strobe_n;
    assign fetch = !bus_i.opcode_fetch_cycle_n && !bus_i.mem_request_n && !bus_i.read_n;
    assign tbl = !bus_i.mem_request_n && !bus_i.read_n && addr_i[15:1] == table_i[15:1];

    // Service flag, ended by the vectored exit byte pair seen in fetches
    always @(posedge clock_i) begin
        fetch_q <= fetch;
        if (ack) begin
            in_service_q <= 1'b1;
        end else if (fetch && !fetch_q) begin
            if (ed_seen_q && code_i == 8'h4D) begin
                in_service_q <= 1'b0;
            end
            ed_seen_q <= (code_i == 8'hED);
        end
    end

    // Released bus toggles rather than holding its last byte
    always @(posedge clock_i) begin
        if (ack) begin
            data_q <= vector_i;
        end else if (fetch) begin
            data_q <= code_i;
        end else if (tbl) begin
            data_q <= addr_i[0] ? entry_i[15:8] : entry_i[7:0];
        end else begin
            data_q <= ~data_q;
        end
    end
endmodule : cir_periph

`default_nettype wire

// ### sim/test_cir_unit.sv
`timescale 1ns/1ps
`default_nettype none

module test_cir_unit;
    import cir_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic nmi_n = 1'b1, int_n = 1'b1, bus_takeover_request_n = 1'b1, halt = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [6:0] ops = 7'h00;
    logic [1:0] kind = 2'h0, htrans = 2'h0;
    logic [7:0] acc = 8'h5C, data;
    logic [15:0] addr;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hready, hresp, pc_hold, enable_flop_primary, enable_flop_shadow, in_svc;
    logic [7:0] code = 8'h00;
    cir_bus_t bus;
    cir_svc_t svc, got;
    logic [19:0] exp_t [3] = '{{1'b1, K_MODE0, 1'b0, 16'h0000},
        {1'b1, K_MODE1, 1'b1, MODE1_ENTRY}, {1'b1, K_MODE2, 1'b1, 16'h3AC4}};
    int num_errors = 0, n_checks = 0;

    cir_unit dut (.clock_i(clock_i), .reset_i(reset_i), .nmi_req_n_i(nmi_n), .int_req_n_i(int_n),
        .bus_takeover_request_n_i(bus_takeover_request_n), .instr_end_i(ops[6]), .halt_i(halt),
        .unmask_op_i(ops[0]), .mask_off_op_i(ops[1]), .response_kind_select_op_i(ops[2]),
        .response_kind_i(kind), .load_page_op_i(ops[3]), .accumulator_i(acc),
        .nonmaskable_exit_op_i(ops[4]), .vectored_exit_op_i(ops[5]), .pc_i(16'h1234),
        .data_i(data), .bus_o(bus), .addr_o(addr), .svc_o(svc), .pc_hold_o(pc_hold),
        .enable_flop_primary_o(enable_flop_primary), .enable_flop_shadow_o(enable_flop_shadow), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp));

    cir_periph peer (.clock_i(clock_i), .bus_i(bus), .addr_i(addr), .vector_i(8'h24),
        .table_i({acc, 8'h24}), .entry_i(16'h3AC4), .code_i(code), .data_o(data),
        .in_service_o(in_svc));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic op(input logic [6:0] m);
        @(posedge clock_i);
        ops <= m;
        @(posedge clock_i);
        ops <= 7'h00;
    endtask : op

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock_i);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic wsvc(output logic hit);
        hit = 1'b0;
        repeat (40) begin
            @(posedge clock_i);
            if (svc.valid === 1'b1 && !hit) begin
                hit = 1'b1;
                got = svc;
            end
        end
    endtask : wsvc

    task automatic try_int(input logic want);
        logic hit;
        op(7'h40);
        wsvc(hit);
        chk("accept", hit, want);
    endtask : try_int

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        complete_run();
    end

    initial begin
        logic hit;
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        // ==========================================================
        // Reset state and masking
        ahb(1'b0, REG_STATUS, 32'h0);
        chk("status", rd[3:0], 4'h0);
        ahb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", rd, RD_ZERO);
        chk("resp", hresp, 1'b0);
        int_n <= 1'b0;
        repeat (3) @(posedge clock_i);
        try_int(1'b0);
        op(7'h01);
        bus_takeover_request_n <= 1'b0;
        repeat (3) @(posedge clock_i);
        try_int(1'b0);
        bus_takeover_request_n <= 1'b1;
        op(7'h02);
        try_int(1'b0);
        int_n <= 1'b1;
        op(7'h08);
        $display("test masking done");
        // ==========================================================
        // Three maskable modes
        for (int m = 0; m < 3; m++) begin
            kind <= m[1:0];
            op(7'h04);
            op(7'h01);
            int_n <= 1'b0;
            halt <= (m == 1);
            repeat (4) @(posedge clock_i);
            if (m != 1) op(7'h40);
            wsvc(hit);
            int_n <= 1'b1;
            halt <= 1'b0;
            chk("svc", got[27:8], exp_t[m]);
            if (m == 0) chk("opcode", got.opcode, 8'h24);
            chk("hold", pc_hold, m == 0);
            ahb(1'b0, REG_STATUS, 32'h0);
            chk("st", {rd[23:16], rd[3:0]}, {acc, m[1:0], 2'h0});
            op(7'h60);
        end
        $display("test modes done");
        // ==========================================================
        // Non-maskable request beats maskable
        op(7'h01);
        nmi_n <= 1'b0;
        int_n <= 1'b0;
        repeat (4) @(posedge clock_i);
        op(7'h40);
        wsvc(hit);
        chk("nmi", got[27:8], {1'b1, K_NMI, 1'b1, NMI_ENTRY});
        chk("flops", {enable_flop_shadow, enable_flop_primary}, 2'h2);
        nmi_n <= 1'b1;
        try_int(1'b0);
        op(7'h10);
        try_int(1'b1);
        int_n <= 1'b1;
        ahb(1'b0, REG_COUNT, 32'h0);
        chk("count", rd, 32'h0004_0001);
        ahb(1'b1, REG_CTRL, 32'h1);
        ahb(1'b0, REG_COUNT, 32'h0);
        chk("cleared", rd, 32'h0);
        $display("test nmi done");
        // ==========================================================
        // Vectored exit byte pair ends peripheral service
        chk("in service", in_svc, 1'b1);
        code <= 8'hED;
        halt <= 1'b1;
        repeat (10) @(posedge clock_i);
        code <= 8'h4D;
        repeat (10) @(posedge clock_i);
        chk("released", in_svc, 1'b0);
        halt <= 1'b0;
        code <= 8'h00;
        $display("test exit decode done");
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        ahb(1'b0, REG_STATUS, 32'h0);
        chk("mode", rd[3:2], MODE_RESET);
        chk("idle", rd[10:4], S_IDLE);
        $display("test reset done");
        complete_run();
    end
endmodule : test_cir_unit

`default_nettype wire
